// >>> src/link_regs_pkg.sv
// Purpose: Constants for the express link control/status register bank
// Assumes: 32-bit classic Wishbone, byte addresses on wb_adr_i[7:0]
// Notes: Offsets are byte addresses; each register is one aligned word
package link_regs_pkg;
	localparam logic [7:0] LINK_CTRL_OFF = 8'hc0;
	localparam logic [7:0] TUNE0_OFF = 8'hcc;
	localparam logic [7:0] TUNE1_OFF = 8'hd0;
	localparam logic [7:0] TUNE2_OFF = 8'hd4;
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] CTRL_WMASK = 16'h00c3;
	localparam logic [15:0] CPM_WMASK = 16'h0100;
	localparam logic [31:0] TUNE0_RST = 32'h04001060;
	localparam logic [31:0] TUNE1_RST = 32'h04000800;
	localparam logic [31:0] TUNE2_RST = 32'h00998254;
	localparam logic [31:0] TUNE0_WMASK = 32'hffffffff;
	localparam logic [31:0] TUNE1_WMASK = 32'hffffffff;
	localparam logic [31:0] TUNE2_WMASK = 32'h00ffffff;
	localparam int ASPM_LSB = 0;
	localparam int RCB_BIT = 3;
	localparam int LDIS_BIT = 4;
	localparam int RETRAIN_BIT = 5;
	localparam int CCLK_BIT = 6;
	localparam int XSYNC_BIT = 7;
	localparam int CPM_BIT = 8;
	localparam int SPEED_LSB = 16;
	localparam int WIDTH_LSB = 20;
	localparam int TRAIN_ERR_BIT = 26;
	localparam int TRAINING_BIT = 27;
	localparam int SLOT_CLK_BIT = 28;
	localparam int DL_INACT_BIT = 29;
	localparam int FORCE_CFG_BIT = 3;
	localparam int LANE_NEG_LSB = 5;
	localparam int L1_TIMER_LSB = 16;
	localparam int CLOCK_RECOVERY_LSB = 0;
	localparam int PD_WAIT_BIT = 23;
	localparam logic [3:0] SPEED_RST = 4'h1;
	localparam logic [5:0] WIDTH_RST = 6'h01;
	localparam logic [2:0] LANE_NEG_RST = 3'h3;
	localparam logic [15:0] L1_TIMER_RST = 16'h0400;
	localparam logic [7:0] CLOCK_RECOVERY_RST = 8'h54;
	localparam logic SLOT_CLK_VAL = 1'b1;
	typedef enum logic [1:0] {
		STRAP_ARMED = 2'b01,
		STRAP_HELD = 2'b10
	} strap_state_t;
endpackage

// >>> src/strap_if.sv
// Purpose: Carries the captured clock PM strap to the register bank
// Assumes: Single clock domain
// Notes: captured rises once after reset release
`timescale 1ns/1ps
interface strap_if;
	logic cpm_ok;
	logic captured;
	modport producer(output cpm_ok, output captured);
	modport consumer(input cpm_ok, input captured);
endinterface

// >>> src/strap_capture.sv
// Purpose: Synchronises the two strap request pins and latches whether both are low
// Assumes: Pins are static around reset release
// Notes: Sampled in the first cycle after srst falls
`timescale 1ns/1ps
module strap_capture (
	input wire logic clock,
	input wire logic srst,
	input wire logic [1:0] strap_req_n,
	strap_if.producer sp
);
	logic [1:0] sync1_reg;
	logic [1:0] sync2_reg;
	link_regs_pkg::strap_state_t state_reg;
	logic cpm_reg;
	wire both_low = (sync2_reg == 2'h0);

	// Synchroniser carries no reset so it tracks the pins through reset
	always_ff @(posedge clock) begin
		sync1_reg <= strap_req_n;
		sync2_reg <= sync1_reg;
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			state_reg <= link_regs_pkg::STRAP_ARMED;
			cpm_reg <= 1'b0;
		end else begin
			case (state_reg)
				link_regs_pkg::STRAP_ARMED: begin
					cpm_reg <= both_low;
					state_reg <= link_regs_pkg::STRAP_HELD;
				end
				link_regs_pkg::STRAP_HELD: begin
					state_reg <= link_regs_pkg::STRAP_HELD;
				end
				default: begin
					state_reg <= link_regs_pkg::STRAP_ARMED;
				end
			endcase
		end
	end

	assign sp.cpm_ok = cpm_reg;
	assign sp.captured = (state_reg == link_regs_pkg::STRAP_HELD);
endmodule

// >>> src/express_link_ctrl_status_regs.sv
// Purpose: Link control/status and phy tuning register bank
// Assumes: Status inputs come from logic on the same clock
// Notes: Wishbone slave answers one cycle after the request
`timescale 1ns/1ps
module express_link_ctrl_status_regs (
	input wire logic clock,
	input wire logic srst,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [1:0] strap_req_n,
	input wire logic [3:0] link_speed_in,
	input wire logic [5:0] link_width_in,
	input wire logic dl_active_in,
	output logic [1:0] aspm_ctrl,
	output logic clock_pm_en,
	output logic common_clock_cfg,
	output logic extended_sync,
	output logic [31:0] phy_tuning_0,
	output logic [31:0] phy_tuning_1,
	output logic [31:0] phy_tuning_2
);
	strap_if sif();

	strap_capture straps (
		.clock(clock),
		.srst(srst),
		.strap_req_n(strap_req_n),
		.sp(sif.producer)
	);

	logic ack_reg;
	logic [31:0] rdat_reg;
	logic [15:0] ctrl_reg;
	logic [15:0] status_reg;
	logic [31:0] tune0_reg;
	logic [31:0] tune1_reg;
	logic [31:0] tune2_reg;
	logic [15:0] ctrl_next;
	logic [15:0] status_next;
	logic [31:0] tune0_next;
	logic [31:0] tune1_next;
	logic [31:0] tune2_next;
	logic [31:0] rdat_next;

	wire [31:0] byte_mask;
	genvar i;
	generate
		for (i = 0; i < 4; i++) begin : g_lane
			assign byte_mask[8*i +: 8] = {8{wb_sel_i[i]}};
		end
	endgenerate

	wire req = wb_cyc_i & wb_stb_i & ~ack_reg;
	wire wr_go = req & wb_we_i;
	wire rd_go = req & ~wb_we_i;
	wire [5:0] word = wb_adr_i[7:2];
	wire hit_ctrl = (word == link_regs_pkg::LINK_CTRL_OFF[7:2]);
	wire hit_t0 = (word == link_regs_pkg::TUNE0_OFF[7:2]);
	wire hit_t1 = (word == link_regs_pkg::TUNE1_OFF[7:2]);
	wire hit_t2 = (word == link_regs_pkg::TUNE2_OFF[7:2]);

	// Clock PM enable bit joins the writable set only when strapped
	wire cpm_writable = sif.captured & sif.cpm_ok;
	wire [15:0] ctrl_wmask = link_regs_pkg::CTRL_WMASK |
		(cpm_writable ? link_regs_pkg::CPM_WMASK : 16'h0000);
	// Read-only bits never enter the mask, so they stay at zero
	wire [15:0] ctrl_m = byte_mask[15:0] & ctrl_wmask;
	wire [31:0] t0_m = byte_mask & link_regs_pkg::TUNE0_WMASK;
	wire [31:0] t1_m = byte_mask & link_regs_pkg::TUNE1_WMASK;
	wire [31:0] t2_m = byte_mask & link_regs_pkg::TUNE2_WMASK;

	assign ctrl_next = (wr_go & hit_ctrl) ?
		((ctrl_reg & ~ctrl_m) | (wb_dat_i[15:0] & ctrl_m)) :
		ctrl_reg;
	assign tune0_next = (wr_go & hit_t0) ?
		((tune0_reg & ~t0_m) | (wb_dat_i & t0_m)) :
		tune0_reg;
	assign tune1_next = (wr_go & hit_t1) ?
		((tune1_reg & ~t1_m) | (wb_dat_i & t1_m)) :
		tune1_reg;
	assign tune2_next = (wr_go & hit_t2) ?
		((tune2_reg & ~t2_m) | (wb_dat_i & t2_m)) :
		tune2_reg;

	// Upper half of the link word; training bits are tied to zero
	assign status_next = {
		2'b00,
		~dl_active_in,
		link_regs_pkg::SLOT_CLK_VAL,
		2'b00,
		link_width_in,
		link_speed_in
	};

	assign rdat_next = ~rd_go ? 32'h00000000 :
		hit_ctrl ? {status_reg, ctrl_reg} :
		hit_t0 ? tune0_reg :
		hit_t1 ? tune1_reg :
		hit_t2 ? tune2_reg :
		32'h00000000;

	always_ff @(posedge clock) begin
		if (srst) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h00000000;
		end else begin
			ack_reg <= req;
			rdat_reg <= rdat_next;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			ctrl_reg <= link_regs_pkg::CTRL_RST;
			tune0_reg <= link_regs_pkg::TUNE0_RST;
			tune1_reg <= link_regs_pkg::TUNE1_RST;
			tune2_reg <= link_regs_pkg::TUNE2_RST;
		end else begin
			ctrl_reg <= ctrl_next;
			tune0_reg <= tune0_next;
			tune1_reg <= tune1_next;
			tune2_reg <= tune2_next;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			status_reg <= {2'b00, 1'b0, link_regs_pkg::SLOT_CLK_VAL,
				2'b00, link_regs_pkg::WIDTH_RST,
				link_regs_pkg::SPEED_RST};
		end else begin
			status_reg <= status_next;
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;
	assign aspm_ctrl = ctrl_reg[link_regs_pkg::ASPM_LSB +: 2];
	assign clock_pm_en = ctrl_reg[link_regs_pkg::CPM_BIT];
	assign common_clock_cfg = ctrl_reg[link_regs_pkg::CCLK_BIT];
	assign extended_sync = ctrl_reg[link_regs_pkg::XSYNC_BIT];
	assign phy_tuning_0 = tune0_reg;
	assign phy_tuning_1 = tune1_reg;
	assign phy_tuning_2 = tune2_reg;

	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	wire rd_ctrl_ack = ack_reg & ~wb_we_i & hit_ctrl;

	ack_one_cycle_a: assert property (
		req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a single cycle after request");

	aspm_reset_a: assert property (
		$fell(srst) |-> aspm_ctrl == 2'h0 && !clock_pm_en)
		else $error("power-state field not disabled after reset");

	aspm_write_a: assert property (
		wr_go && hit_ctrl && wb_sel_i[0] |=>
		aspm_ctrl == $past(wb_dat_i[1:0]))
		else $error("power-state field did not take write");

	rcb_zero_a: assert property (
		rd_ctrl_ack |-> wb_dat_o[link_regs_pkg::RCB_BIT] == 1'b0)
		else $error("completion boundary bit read nonzero");

	cpm_locked_a: assert property (
		!sif.cpm_ok |-> !clock_pm_en)
		else $error("clock PM enable set without strap");

	cpm_wait_a: assert property (
		!sif.captured |-> !clock_pm_en)
		else $error("clock PM enable set before strap capture");

	speed_track_a: assert property (
		!$past(srst) |-> status_reg[3:0] == $past(link_speed_in))
		else $error("link speed not tracking input");

	dl_invert_a: assert property (
		!$past(srst) |-> status_reg[13] == !$past(dl_active_in))
		else $error("link active bit not inverted");

	tune0_write_a: assert property (
		wr_go && hit_t0 && wb_sel_i == 4'hf |=>
		tune0_reg == $past(wb_dat_i))
		else $error("tuning 0 did not take full write");

	tune2_reset_a: assert property (
		$fell(srst) |->
		tune2_reg[7:0] == link_regs_pkg::CLOCK_RECOVERY_RST &&
		tune2_reg[link_regs_pkg::PD_WAIT_BIT])
		else $error("tuning 2 reset value wrong");

	width_reset_a: assert property (
		$fell(srst) |-> status_reg[9:4] == link_regs_pkg::WIDTH_RST)
		else $error("width not one lane after reset");

	ro_bits_zero_a: assert property (
		rd_ctrl_ack |-> wb_dat_o[5:4] == 2'h0 && wb_dat_o[27:26] == 2'h0)
		else $error("read-only link bits not zero");

	write_ctrl_c: cover property (wr_go && hit_ctrl ##1 wb_ack_o);
	read_status_c: cover property (rd_ctrl_ack);
	cpm_write_c: cover property (
		sif.cpm_ok && wr_go && hit_ctrl && wb_dat_i[8]
		##1 clock_pm_en);
	unmapped_c: cover property (req && !hit_ctrl && !hit_t0 &&
		!hit_t1 && !hit_t2);
endmodule

// >>> tb/link_partner.sv
// Purpose: Far-side link model reporting speed, width and link state
// Assumes: Same clock as the register bank
// Notes: Lane index picks one width code, 0 to 6 only
`timescale 1ns/1ps
module link_partner (
	input wire logic clock,
	input wire logic srst,
	input wire logic [2:0] lane_idx,
	input wire logic link_up,
	output logic [3:0] speed,
	output logic [5:0] width,
	output logic dl_active
);
	logic [5:0] width_code;
	assign width_code = (lane_idx == 3'h4) ? 6'h0c :
		(lane_idx > 3'h4) ? 6'h01 << (lane_idx - 3'h1) : 6'h01 << lane_idx;
	always_ff @(posedge clock) begin
		speed <= 4'h1;
		width <= srst ? 6'h01 : width_code;
		dl_active <= srst ? 1'b0 : link_up;
	end
endmodule

// >>> tb/express_link_ctrl_status_regs_bench.sv
// Purpose: Self-checking bench for the link register bank
// Assumes: Slave acks each request on the second clock edge after the bench drives it
// Notes: Repeated over all four strap settings
`timescale 1ns/1ps
`define CK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
	errors++; $display("Error %s expected %h seen %h", n, e, g); end end
module express_link_ctrl_status_regs_bench;
	logic clock, srst, cyc, stb, we, ack, link_up, dl_active, cpm_ok;
	logic cpm_en, cc_cfg, ext_sync;
	logic [7:0] adr;
	logic [3:0] sel, speed;
	logic [31:0] wdat, rdat, tune_0, tune_1, tune_2, d, x;
	logic [1:0] strap_n, aspm;
	logic [5:0] width;
	logic [2:0] lane_idx;
	logic [15:0] lfsr_reg, ctrl_m;
	logic [31:0] tune_m [3];
	logic [5:0] wtab [7] = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h20};
	logic [7:0] atab [5] = '{8'hc0, 8'hcc, 8'hd0, 8'hd4, 8'hc4};
	int errors, tests_run;
	express_link_ctrl_status_regs express_link_ctrl_status_regs_inst (
		.clock(clock), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .strap_req_n(strap_n),
		.link_speed_in(speed), .link_width_in(width),
		.dl_active_in(dl_active), .aspm_ctrl(aspm), .clock_pm_en(cpm_en),
		.common_clock_cfg(cc_cfg), .extended_sync(ext_sync),
		.phy_tuning_0(tune_0), .phy_tuning_1(tune_1), .phy_tuning_2(tune_2));
	link_partner link_partner_inst (.clock(clock), .srst(srst),
		.lane_idx(lane_idx), .link_up(link_up), .speed(speed),
		.width(width), .dl_active(dl_active));
	function automatic logic [15:0] lfsr_next(input logic [15:0] l);
		return {l[14:0], l[15] ^ l[13] ^ l[12] ^ l[10]};
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, n, m,
		input logic [3:0] s);
		logic [31:0] b;
		b = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}} & m;
		return (o & ~b) | (n & b);
	endfunction
	// Status half: bit 28 fixed high, bit 29 high while link is down
	function automatic logic [31:0] c0_exp(input logic [15:0] c,
		input logic [2:0] i, input logic up);
		return {2'b00, ~up, 1'b1, 2'b00, wtab[i], 4'h1, c};
	endfunction
	task automatic rnd(output logic [31:0] v);
		lfsr_reg = lfsr_next(lfsr_reg);
		v[15:0] = lfsr_reg;
		lfsr_reg = lfsr_next(lfsr_reg);
		v[31:16] = lfsr_reg;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] dv, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clock);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= dv;
		do begin
			@(posedge clock);
			n++;
		end while (ack !== 1'b1);
		r = rdat;
		`CK("ack_wait", 2, n)
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] dv);
		logic [31:0] r;
		wb(1'b1, a, s, dv, r);
		r = merge({16'h0, ctrl_m}, dv, cpm_ok ? 32'h1c3 : 32'hc3, s);
		if (a == 8'hc0) ctrl_m = r[15:0];
		if (a >= 8'hcc) tune_m[(a - 8'hcc) / 4] = merge(tune_m[(a - 8'hcc) / 4],
			dv, (a == 8'hd4) ? 32'h00ffffff : 32'hffffffff, s);
	endtask
	task automatic chk_all();
		logic [31:0] r;
		wb(1'b0, 8'hc0, 4'hf, 32'h0, r);
		`CK("lw", c0_exp(ctrl_m, lane_idx, link_up), r)
		`CK("lw11", wtab[lane_idx], r[25:20])
		for (int i = 0; i < 3; i++) begin
			wb(1'b0, 8'hcc + 8'(4 * i), 4'hf, 32'h0, r);
			`CK("tune", tune_m[i], r)
		end
		wb(1'b0, 8'hc4, 4'hf, 32'h0, r);
		`CK("hole", 32'h0, r)
		`CK("pins", {ctrl_m[8:6], ctrl_m[1:0], tune_m[0], tune_m[1], tune_m[2]},
			{cpm_en, ext_sync, cc_cfg, aspm, tune_0, tune_1, tune_2})
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		repeat (20000) @(posedge clock);
		errors++;
		results();
	end
	initial begin
		{srst, cyc, stb, we, link_up} = 5'h10;
		{adr, sel, wdat, lane_idx} = '0;
		{errors, tests_run, strap_n, lfsr_reg} = {32'd0, 32'd0, 2'b11, 16'h4523};
		for (int s = 0; s < 4; s++) begin
			strap_n <= 2'(3 - s);
			srst <= 1'b1;
			repeat (5) @(posedge clock);
			srst <= 1'b0;
			repeat (3) @(posedge clock);
			cpm_ok = (s == 3);
			ctrl_m = 16'h0000;
			// Lane count 3, TS1 10h, L1 timer 0400h; lifetimes; FTS 54h, wait set
			tune_m = '{32'h04001060, 32'h04000800, 32'h00998254};
			chk_all();
			wr(8'hc0, 4'hf, 32'hffffffff);
			chk_all();
			for (int i = 0; i < 16; i++) begin
				rnd(d);
				rnd(x);
				lane_idx <= 3'(x[10:8] % 7);
				link_up <= x[11];
				if (i < 4) d[1:0] = 2'(i);
				wr((i < 4) ? 8'hc0 : atab[x[2:0] % 5], x[7:4] | 4'(i < 4), d);
				chk_all();
			end
			$display("test strap %0d done", s);
		end
		results();
	end
endmodule
